// ===== inc/adc_ctl_pkg.sv
// Constants and types of the converter control plane.
// Assumes one input clock at 250 MHz and registers reached over the 3-wire serial port.
`default_nettype none
package adc_ctl_pkg;
  localparam logic [6:0] REG_CLKDIV = 7'h06;
  localparam logic [6:0] REG_RSVD   = 7'h07;
  localparam logic [6:0] REG_CM     = 7'h08;
  localparam logic [6:0] REG_TIMING = 7'h09;
  localparam logic [6:0] REG_SWRST  = 7'h0a;
  localparam logic [7:0] SWRST_KEY  = 8'h5a;
  localparam logic [7:0] CLKDIV_RST = 8'h00;
  localparam logic [7:0] CM_RST     = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h80;
  localparam int SYNC_MODE_BIT = 2;
  localparam int RW_BIT        = 15;
  localparam logic [3:0] HDR_LAST   = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'hf;
  localparam logic [1:0] DIV_2 = 2'b01;
  localparam logic [1:0] DIV_4 = 2'b10;
  localparam logic [1:0] HALF_2 = 2'h1;
  localparam logic [1:0] HALF_4 = 2'h2;
  localparam logic [1:0] SYNC_ACT = 2'h2;
  localparam int LATENCY = 9;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ALIGN_SAVE_PS = 3400;
  localparam logic [2:0] ALIGN_CYC =
    (ALIGN_SAVE_PS / CLK_PERIOD_PS < 1) ? 3'h1 : 3'(ALIGN_SAVE_PS / CLK_PERIOD_PS);
  localparam logic [3:0] LEAD_BASE = 4'h2;
  localparam logic [10:0] CM_MV [8] = '{11'd900, 11'd1050, 11'd1200, 11'd1350,
                                        11'd900, 11'd750, 11'd600, 11'd450};
  typedef struct packed {
    logic [9:0] chan_b;
    logic [9:0] chan_a;
  } sample_pair_s;
  typedef struct packed {
    logic       chan_b_self_bias_connect;
    logic [2:0] chan_b_cm_level_sel;
    logic       chan_a_self_bias_connect;
    logic [2:0] chan_a_cm_level_sel;
  } cm_cfg_s;
  typedef struct packed {
    logic       aligner_skip;
    logic       half_period_shift;
    logic [2:0] outclk_delay_code;
    logic [2:0] data_delay_code;
  } timing_cfg_s;
  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_IN   = 3'b010,
    SP_RD   = 3'b100
  } sport_e;
endpackage : adc_ctl_pkg
`default_nettype wire

// ===== rtl/adc_clk_ctl.sv
// Divider, sync, output pipeline and configuration registers of the converter.
// Assumes serial port pins, straps and sync are synchronous to clock_i.
`default_nettype none
module adc_clk_ctl (
  input  wire logic                      clock_i,
  input  wire logic                      rstn_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      sclk_i,
  input  wire logic                      sdio_i,
  output var  logic                      sdio_o,
  output var  logic                      sdio_oe_n_o,
  input  wire logic                      serial_port_disable_pin_i,
  input  wire logic [1:0]                div_strap_i,
  input  wire logic                      power_down_pin_i,
  input  wire logic                      sync_i,
  input  wire logic                      mux_mode_i,
  input  wire adc_ctl_pkg::sample_pair_s adc_sample_i,
  output var  logic                      samp_clk_o,
  output var  adc_ctl_pkg::sample_pair_s data_o,
  output var  logic                      output_clock_o,
  output var  adc_ctl_pkg::cm_cfg_s      cm_o,
  output var  logic [10:0]               chan_a_cm_mv_o,
  output var  logic [10:0]               chan_b_cm_mv_o,
  output var  adc_ctl_pkg::timing_cfg_s  timing_o,
  output var  logic [3:0]                outclk_lead_o
);
  import adc_ctl_pkg::*;

  // ****************************************
  // Serial port
  // ****************************************
  sport_e      sp_q;
  logic        sclk_q;
  logic [3:0]  cnt_q;
  logic [15:0] sh_q;
  logic [7:0]  out_q;
  logic [7:0]  clkdiv_q;
  cm_cfg_s     cm_q;
  timing_cfg_s timing_q;
  logic        pd_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sp_on;
  logic        wr_go;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        hw_rst;
  logic        sw_rst;

  assign sclk_rise = sclk_i & ~sclk_q;
  assign sclk_fall = ~sclk_i & sclk_q;
  assign sp_on     = ~cs_n_i & ~serial_port_disable_pin_i;
  assign wr_go     = sp_on && sp_q == SP_IN && sclk_rise && cnt_q == FRAME_LAST;
  assign wr_addr   = sh_q[13:7];
  assign wr_data   = {sh_q[6:0], sdio_i};
  assign rd_addr   = {sh_q[5:0], sdio_i};

  always_comb begin
    case (rd_addr)
      REG_CLKDIV: rd_data = clkdiv_q;
      REG_CM:     rd_data = cm_q;
      REG_TIMING: rd_data = timing_q;
      default:    rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_q        <= SP_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 16'h0000;
      out_q       <= 8'h00;
      sdio_oe_n_o <= 1'b1;
    end else if (!sp_on) begin
      sp_q        <= SP_IDLE;
      cnt_q       <= 4'h0;
      sdio_oe_n_o <= 1'b1;
    end else begin
      case (sp_q)
        SP_IDLE: begin
          sp_q  <= SP_IN;
          cnt_q <= 4'h0;
        end
        SP_IN: begin
          if (sclk_rise) begin
            sh_q  <= {sh_q[14:0], sdio_i};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == HDR_LAST && sh_q[6]) begin
              sp_q        <= SP_RD;
              out_q       <= rd_data;
              sdio_oe_n_o <= 1'b0;
            end else if (cnt_q == FRAME_LAST) begin
              sp_q <= SP_IDLE;
            end
          end
        end
        SP_RD: begin
          if (sclk_fall) begin
            out_q <= {out_q[6:0], 1'b0};
          end
        end
        default: sp_q <= SP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdio_o <= 1'b0;
    end else begin
      sdio_o <= out_q[7];
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  assign sw_rst = wr_go && wr_addr == REG_SWRST && wr_data == SWRST_KEY;
  assign hw_rst = serial_port_disable_pin_i & pd_q & ~power_down_pin_i;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= power_down_pin_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clkdiv_q <= CLKDIV_RST;
      cm_q     <= CM_RST;
      timing_q <= TIMING_RST;
    end else if (sw_rst || hw_rst) begin
      clkdiv_q <= CLKDIV_RST;
      cm_q     <= CM_RST;
      timing_q <= TIMING_RST;
    end else if (wr_go) begin
      // Reserved slot and unmapped writes fall through untouched
      case (wr_addr)
        REG_CLKDIV: clkdiv_q <= wr_data;
        REG_CM:     cm_q     <= wr_data;
        REG_TIMING: timing_q <= wr_data;
        default:    ;
      endcase
    end
  end

  // ****************************************
  // Analog-facing settings
  // ****************************************
  logic [3:0] ph_d;
  logic [3:0] ph_c;

  always_comb begin
    ph_d = {2'b00, timing_q.data_delay_code[1:0]};
    ph_c = {2'b00, timing_q.outclk_delay_code[1:0]};
    if (timing_q.data_delay_code[2]) begin
      ph_d = 4'h0 - ph_d;
    end
    if (timing_q.outclk_delay_code[2]) begin
      ph_c = 4'h0 - ph_c;
    end
  end

  assign cm_o     = cm_q;
  assign timing_o = timing_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_a_cm_mv_o <= CM_MV[0];
      chan_b_cm_mv_o <= CM_MV[0];
      outclk_lead_o  <= LEAD_BASE;
    end else begin
      chan_a_cm_mv_o <= CM_MV[cm_q.chan_a_cm_level_sel];
      chan_b_cm_mv_o <= CM_MV[cm_q.chan_b_cm_level_sel];
      outclk_lead_o  <= ph_d - ph_c + LEAD_BASE;
    end
  end

  // ****************************************
  // Divider and synchronisation
  // ****************************************
  logic [1:0] ratio;
  logic       ratio_none;
  logic [1:0] half;
  logic [1:0] div_q;
  logic [1:0] div_nxt;
  logic       sync_prev_q;
  logic [1:0] sync_cnt_q;
  logic       sync_rise;
  logic       sync_act;
  logic       edge_mode;
  logic       samp_en;

  assign ratio      = serial_port_disable_pin_i ? div_strap_i : clkdiv_q[1:0];
  assign ratio_none = ratio != DIV_2 && ratio != DIV_4;
  assign half       = ratio == DIV_4 ? HALF_4 : HALF_2;
  assign edge_mode  = clkdiv_q[SYNC_MODE_BIT];
  assign sync_rise  = sync_i & ~sync_prev_q;
  assign sync_act   = sync_cnt_q == SYNC_ACT;

  always_comb begin
    if (ratio_none) begin
      div_nxt = 2'h0;
    end else if (sync_act && edge_mode) begin
      div_nxt = 2'h0;
    end else if (sync_act) begin
      div_nxt = div_q;
    end else if (ratio == DIV_2) begin
      div_nxt = {1'b0, ~div_q[0]};
    end else begin
      div_nxt = div_q + 2'h1;
    end
  end

  // Divided clock is high for one cycle as the divider enters the state given by half
  assign samp_en = ratio_none | (div_nxt == half && div_q != half);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_prev_q <= 1'b0;
      sync_cnt_q  <= 2'h0;
    end else begin
      sync_prev_q <= sync_i;
      if (sync_act || ratio_none) begin
        sync_cnt_q <= 2'h0;
      end else if (sync_cnt_q != 2'h0 || sync_rise) begin
        sync_cnt_q <= sync_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q      <= 2'h0;
      samp_clk_o <= 1'b0;
    end else begin
      div_q      <= div_nxt;
      samp_clk_o <= samp_en;
    end
  end

  // ****************************************
  // Sample pipeline and output launch
  // ****************************************
  // Output register is the last of the nine stages
  sample_pair_s pipe_q [LATENCY-1];
  sample_pair_s st_q;
  logic         pend_q;
  logic [2:0]   dly_q;
  logic [2:0]   extra;
  logic         half_eff;

  assign half_eff = timing_q.half_period_shift & ~mux_mode_i & ~ratio_none;
  assign extra    = (timing_q.aligner_skip ? 3'h0 : ALIGN_CYC)
                  + (half_eff ? {1'b0, half} : 3'h0);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LATENCY-1; i++) begin
        pipe_q[i] <= '0;
      end
    end else if (samp_en) begin
      pipe_q[0] <= adc_sample_i;
      for (int i = 1; i < LATENCY-1; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q           <= '0;
      pend_q         <= 1'b0;
      dly_q          <= 3'h0;
      data_o         <= '0;
      output_clock_o <= 1'b0;
    end else begin
      output_clock_o <= 1'b0;
      if (pend_q) begin
        if (dly_q == 3'h0) begin
          data_o         <= st_q;
          output_clock_o <= 1'b1;
          pend_q         <= 1'b0;
        end else begin
          dly_q <= dly_q - 3'h1;
        end
      end
      if (samp_en) begin
        if (extra == 3'h0) begin
          data_o         <= pipe_q[LATENCY-2];
          output_clock_o <= 1'b1;
        end else begin
          st_q   <= pipe_q[LATENCY-2];
          dly_q  <= extra - 3'h1;
          pend_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  logic [3:0] steady_q;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      steady_q <= 4'h0;
    end else if (!(ratio_none && extra == 3'h0)) begin
      steady_q <= 4'h0;
    end else if (steady_q != 4'hf) begin
      steady_q <= steady_q + 4'h1;
    end
  end

  property p_lat;
    (steady_q >= 4'ha) |=> data_o == $past(adc_sample_i, 9);
  endproperty
  a_lat: assert property (p_lat) else $error("latency not nine");

  property p_slip;
    (!ratio_none && sync_act && !edge_mode) |=> div_q == $past(div_q);
  endproperty
  a_slip: assert property (p_slip) else $error("slip missing");

  property p_edge;
    (!ratio_none && sync_act && edge_mode) |=> div_q == 2'h0;
  endproperty
  a_edge: assert property (p_edge) else $error("edge force missing");

  property p_edge2;
    (sync_rise && sync_cnt_q == 2'h0 && ratio == DIV_2 && edge_mode)
      ##0 (ratio == DIV_2 && edge_mode)[*5] |-> samp_clk_o;
  endproperty
  a_edge2: assert property (p_edge2) else $error("edge /2 timing");

  property p_edge4;
    (sync_rise && sync_cnt_q == 2'h0 && ratio == DIV_4 && edge_mode)
      ##0 (ratio == DIV_4 && edge_mode)[*6] |-> samp_clk_o;
  endproperty
  a_edge4: assert property (p_edge4) else $error("edge /4 timing");

  property p_nodiv;
    ratio_none |=> samp_clk_o;
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("undivided clock gap");

  property p_swrst;
    sw_rst |=> clkdiv_q == CLKDIV_RST && cm_q == CM_RST && timing_q == TIMING_RST;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset ignored");

  property p_hwrst;
    (serial_port_disable_pin_i && $fell(power_down_pin_i))
      |-> ##1 (timing_q == TIMING_RST && clkdiv_q == CLKDIV_RST);
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("pin reset ignored");

  property p_mux;
    (samp_en && mux_mode_i && timing_q.aligner_skip) |=> output_clock_o;
  endproperty
  a_mux: assert property (p_mux) else $error("mux data delayed");

  property p_cm;
    (cm_q.chan_b_cm_level_sel == 3'h4) |=> chan_b_cm_mv_o == CM_MV[0];
  endproperty
  a_cm: assert property (p_cm) else $error("level 100 not 0.9V");

  c_slip: cover property (!ratio_none && sync_act && !edge_mode);
  c_edge: cover property (!ratio_none && sync_act && edge_mode);
  c_swrst: cover property (sw_rst);
  c_late: cover property (pend_q && dly_q == 3'h0);

endmodule : adc_clk_ctl
`default_nettype wire

// ===== tb/adc_clk_ctl_bench.sv
// Bench for the converter control block: serial frames, divider, sync, pipeline.
// Assumes the package and the receive model are compiled first.
`default_nettype none
module adc_clk_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctl_pkg::*;
  // *****
  // Signals
  // *****
  logic         clock_i = 1'b0;
  logic         rstn_i, cs_n_i, sclk_i, sdio_i, sdio_o, sdio_oe_n_o;
  logic         serial_port_disable_pin, power_down_pin, sync_i, mux_i;
  logic         samp_clk_o, oclk;
  logic [1:0]   strap;
  logic [3:0]   lead;
  logic [7:0]   rd, v;
  logic [10:0]  mv_a, mv_b;
  sample_pair_s smp, data_o, rx_word;
  cm_cfg_s      cm_o;
  timing_cfg_s  timing_o;
  logic [7:0]   tbl[4];
  logic [5:0]   ex[4];
  int           mv[8] = '{900, 1050, 1200, 1350, 900, 750, 600, 450};
  int           mismatches = 0;
  int           num_checks = 0;
  int           cyc = 0;
  int           n;

  always #2 clock_i = ~clock_i;

  adc_clk_ctl u_dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o),
    .serial_port_disable_pin_i(serial_port_disable_pin), .div_strap_i(strap),
    .power_down_pin_i(power_down_pin), .sync_i(sync_i), .mux_mode_i(mux_i),
    .adc_sample_i(smp), .samp_clk_o(samp_clk_o), .data_o(data_o),
    .output_clock_o(oclk), .cm_o(cm_o), .chan_a_cm_mv_o(mv_a), .chan_b_cm_mv_o(mv_b),
    .timing_o(timing_o), .outclk_lead_o(lead)
  );

  adc_rx_model u_rx (
    .clock_i(clock_i), .rstn_i(rstn_i), .output_clock_i(oclk), .data_i(data_o),
    .word_o(rx_word)
  );
  // *****
  // Tasks
  // *****
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic frame(input logic [15:0] f);
    cs_n_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sclk_i = 1'b0;
      sdio_i = f[15-i];
      @(negedge clock_i);
      if (i >= 8) rd[15-i] = sdio_o;
      @(negedge clock_i);
      sclk_i = 1'b1;
      repeat (2) @(negedge clock_i);
    end
    sclk_i = 1'b0;
    cs_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
  endtask : frame

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({1'b0, a, d});
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp, input string what);
    frame({1'b1, a, 8'h00});
    chk(what, 32'(exp), 32'(rd));
  endtask : rdc

  task automatic pulses(input int win, input int exp, input string what);
    int c;
    c = 0;
    repeat (win) begin
      @(negedge clock_i);
      if (samp_clk_o === 1'b1) c++;
    end
    chk(what, 32'(exp), 32'(c));
  endtask : pulses

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // *****
  // Sequence
  // *****
  initial begin
    rstn_i = 1'b0;
    cs_n_i = 1'b1;
    sclk_i = 1'b0;
    sdio_i = 1'b0;
    serial_port_disable_pin = 1'b0;
    power_down_pin = 1'b0;
    sync_i = 1'b0;
    mux_i = 1'b0;
    strap = 2'h0;
    smp = '0;
    repeat (16) @(negedge clock_i);
    rstn_i = 1'b1;
    @(negedge clock_i);
    chk("cm reset", 32'h0, 32'(cm_o));
    chk("mv reset", 32'd900, 32'(mv_a));
    chk("lead reset", 32'h2, 32'(lead));
    chk("oe reset", 32'h1, 32'(sdio_oe_n_o));
    for (int c = 0; c < 8; c++) begin
      v = {c[0], 3'(c), ~c[0], 3'(7 - c)};
      wr(REG_CM, v);
      chk("cm reg", 32'(v), 32'(cm_o));
      chk("mv b", 32'(mv[c]), 32'(mv_b));
      chk("mv a", 32'(mv[7-c]), 32'(mv_a));
    end
    rdc(REG_CM, 8'hf0, "cm read");
    wr(7'h0b, 8'hff);
    rdc(REG_RSVD, 8'h00, "rsvd read");
    chk("cm kept", 32'hf0, 32'(cm_o));
    tbl = '{8'h9b, 8'hab, 8'hbd, 8'h80};
    ex = '{6'h2, 6'h6, 6'h4, 6'h2};
    for (int k = 0; k < 4; k++) begin
      wr(REG_TIMING, tbl[k]);
      chk("timing reg", 32'(tbl[k]), 32'(timing_o));
      chk("clock lead", 32'(ex[k][3:0]), 32'(lead));
    end
    for (int k = 0; k < 2; k++) begin
      wr(REG_TIMING, k ? 8'h00 : 8'h80);
      smp = k ? 20'h5a3c1 : 20'h3c5a6;
      n = 0;
      while (data_o !== smp && n < 30) begin
        @(negedge clock_i);
        n++;
      end
      chk("latency", 32'(LATENCY + k), 32'(n));
      chk("out clock", 32'h1, 32'(oclk));
      @(negedge clock_i);
      chk("rx word", 32'(smp), 32'(rx_word));
    end
    wr(REG_SWRST, 8'h5b);
    chk("no reset", 32'hf0, 32'(cm_o));
    wr(REG_SWRST, SWRST_KEY);
    chk("soft reset", 32'h0, 32'(cm_o));
    chk("timing reset", 32'h80, 32'(timing_o));
    rdc(REG_SWRST, 8'h00, "key read");
    tbl = '{8'h01, 8'h02, 8'h03, 8'h00};
    ex = '{6'd20, 6'd10, 6'd40, 6'd40};
    for (int k = 0; k < 4; k++) begin
      wr(REG_CLKDIV, tbl[k]);
      pulses(40, ex[k], "sample clocks");
    end
    for (int k = 1; k < 3; k++) begin
      wr(REG_CLKDIV, 8'(4 + k));
      sync_i = 1'b1;
      repeat (k + 2) @(negedge clock_i);
      chk("forced zero", 32'h0, 32'(samp_clk_o));
      @(negedge clock_i);
      chk("first rise", 32'h1, 32'(samp_clk_o));
      sync_i = 1'b0;
      repeat (4) @(negedge clock_i);
    end
    wr(REG_CLKDIV, 8'h04);
    sync_i = 1'b1;
    pulses(12, 12, "no division sync");
    sync_i = 1'b0;
    wr(REG_CLKDIV, 8'h01);
    n = 0;
    while (samp_clk_o !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    sync_i = 1'b1;
    repeat (10) @(negedge clock_i);
    chk("slip low", 32'h0, 32'(samp_clk_o));
    @(negedge clock_i);
    chk("slip high", 32'h1, 32'(samp_clk_o));
    sync_i = 1'b0;
    wr(REG_TIMING, 8'hc0);
    n = 0;
    while (samp_clk_o !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    chk("half shift early", 32'h0, 32'(oclk));
    @(negedge clock_i);
    chk("half shift late", 32'h1, 32'(oclk));
    mux_i = 1'b1;
    n = 0;
    while (samp_clk_o !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    chk("mux no shift", 32'h1, 32'(oclk));
    mux_i = 1'b0;
    wr(REG_CM, 8'h77);
    serial_port_disable_pin = 1'b1;
    strap = 2'b10;
    wr(REG_CM, 8'h00);
    chk("parallel refuse", 32'h77, 32'(cm_o));
    pulses(40, 10, "strap ratio");
    power_down_pin = 1'b1;
    @(negedge clock_i);
    power_down_pin = 1'b0;
    repeat (2) @(negedge clock_i);
    chk("pin reset", 32'h0, 32'(cm_o));
    give_verdict();
  end
endmodule : adc_clk_ctl_bench
`default_nettype wire

// ===== tb/adc_rx_model.sv
// Receive side model: latches each output word on the output clock pulse.
// Assumes output clock and data are launched from clock_i.
`default_nettype none
module adc_rx_model (
  input  wire logic                      clock_i,
  input  wire logic                      rstn_i,
  input  wire logic                      output_clock_i,
  input  wire adc_ctl_pkg::sample_pair_s data_i,
  output var  adc_ctl_pkg::sample_pair_s word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctl_pkg::*;
  // *****
  // Capture
  // *****
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_o <= '0;
    end else if (output_clock_i) begin
      word_o <= data_i;
    end
  end
endmodule : adc_rx_model
`default_nettype wire
